// ---- core/mlt_pkg.sv ----
package mlt_pkg;
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_AGE = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_KVID = 8'h0C;
  localparam logic [7:0] OFS_KLO = 8'h10;
  localparam logic [7:0] OFS_KHI = 8'h14;
  localparam logic [7:0] OFS_KPRT = 8'h18;
  localparam logic [7:0] OFS_CMD = 8'h1C;
  localparam logic [7:0] OFS_RINFO = 8'h20;
  localparam logic [7:0] OFS_RLO = 8'h24;
  localparam logic [7:0] OFS_RHI = 8'h28;
  localparam logic [7:0] OFS_RPRT = 8'h2C;
  localparam logic [7:0] OFS_SCNT = 8'h30;
  // Field positions
  localparam int CTRL_AGE_OFF = 0;
  localparam int STS_BUSY = 0;
  localparam int STS_ERR = 1;
  localparam int STS_END = 2;
  localparam int INFO_STA = 16;
  localparam int INFO_END = 17;
  // Entry layout
  localparam int E_VLD = 0;
  localparam int E_STA = 1;
  localparam int E_HIT = 2;
  localparam int E_VID = 3;
  localparam int E_ADR = 15;
  localparam int E_PRT = 63;
  // Reset values and limits
  localparam logic [23:0] AGE_RST = 24'h00012C;
  localparam logic [23:0] AGE_MIN = 24'h00000A;
  localparam logic [23:0] AGE_MAX = 24'h989680;
  localparam logic [6:0] STATIC_MAX = 7'h40;
  localparam logic [1:0] MODE_AUTO = 2'h0;
  localparam logic [1:0] MODE_OFF = 2'h1;
  localparam logic [1:0] MODE_SECURE = 2'h2;
  localparam logic [2:0] CMD_ADD = 3'h1;
  localparam logic [2:0] CMD_DEL = 3'h2;
  localparam logic [2:0] CMD_FLUSH = 3'h3;
  localparam logic [2:0] CMD_NEXT = 3'h4;
  // Timing
  localparam int CLK_NS = 10;
  localparam int SEC_NS = 1000000000;
  localparam int CPS_DEF = SEC_NS / CLK_NS;
endpackage

// ---- core/mlt_ram.sv ----
`timescale 1ns/100ps
module mlt_ram #(
  parameter int W = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic pclk,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data_q,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data
);
  logic [W-1:0] mem [DEPTH];

  // Registered read, separate write port
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_q <= mem[rd_addr];
  end
endmodule

// ---- core/mlt_age_timer.sv ----
`timescale 1ns/100ps
module mlt_age_timer #(
  parameter int CPS = 100
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [23:0] age_secs,
  input wire logic off,
  output logic tick_q
);
  localparam int PW = $clog2(CPS);
  localparam logic [PW-1:0] PRE_END = PW'(CPS - 1);
  logic [PW-1:0] pre_q;
  logic [23:0] sec_q;

  if (CPS < 2) begin : g_chk
    $error("CPS too small");
  end

  // Seconds prescaler and aging period counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
      sec_q <= '0;
      tick_q <= 1'b0;
    end else if (off) begin
      pre_q <= '0;
      sec_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (pre_q == PRE_END) begin
        pre_q <= '0;
        if (sec_q >= age_secs - 24'h000001) begin
          sec_q <= '0;
          tick_q <= 1'b1;
        end else begin
          sec_q <= sec_q + 24'h000001;
        end
      end else begin
        pre_q <= pre_q + 1'b1;
      end
    end
  end
endmodule

// ---- core/mlt_table.sv ----
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/100ps
// Summary of operation
// - Each frame's destination address plus VLAN is looked up to give egress ports.
// - Entries carry a static or dynamic flag; both kinds share one lookup.
// - Source address of each frame on an auto mode port inserts or refreshes a dynamic entry.
// - Dynamic entries unseen as source for the aging time are removed.
// - Aging time is whole seconds, 10 to 10000000, reset to 300.
// - A control bit turns aging off; then nothing is aged out.
// - Auto mode learns unknown sources at once; disabled mode learns nothing.
// - Secure mode learns nothing and drops frames without a static source match.
// - Mode writes are ignored while another function owns the port's mode.
// - At most 64 static entries, keyed by VLAN and address, with ports.
// - Reads come back in ascending VLAN then address order.
// - Each entry holds a port bit vector that management can rewrite.
// - The whole table holds up to 8192 entries.
// - Flush removes all dynamic entries and keeps static ones.
// - Get-next returns the equal or next greater key, else end of table.
// - Search results give type, VLAN, address and port set.
// - A committed delete removes the static entry with that key.
module mlt_table
  import mlt_pkg::*;
#(
  parameter int NP = 8,
  parameter int DEPTH = 8192,
  parameter int CYC_PER_SEC = CPS_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lk_valid,
  output logic lk_ready,
  input wire logic [$clog2(NP)-1:0] lk_port,
  input wire logic [11:0] lk_vid,
  input wire logic [47:0] lk_destination_station_address,
  input wire logic [47:0] lk_source_station_address,
  input wire logic [NP-1:0] ext_own,
  input wire logic [2*NP-1:0] ext_mode,
  output logic res_valid,
  output logic [NP-1:0] res_ports,
  output logic res_drop
);
  localparam int AW = $clog2(DEPTH);
  localparam int PW = $clog2(NP);
  localparam int EW = E_PRT + NP;
  localparam logic [AW:0] CNT_END = (AW+1)'(DEPTH);

  typedef enum logic [2:0] {ST_IDLE, ST_DST, ST_SRC, ST_MGMT, ST_SWEEP} mlt_state_t;
  typedef enum logic [1:0] {SW_INIT, SW_AGE, SW_FLUSH, SW_NEXT} mlt_sweep_t;

  if (NP < 2 || NP > 16 || DEPTH < 64 || (1 << AW) != DEPTH) begin : g_chk
    $error("Unsupported NP or DEPTH");
  end

  mlt_state_t state_q, state_d;
  mlt_sweep_t sw_kind_q, go_kind;
  logic [AW:0] sw_cnt_q;
  logic [EW-1:0] rd_ent, wd, best_q, res_ent_q;
  logic [AW-1:0] rd_addr, wa;
  logic we, go_lk, best_vld_q, res_end_q;
  logic [11:0] l_vid_q, key_vid_q;
  logic [47:0] l_dst_q, l_src_q, key_addr_q;
  logic [PW-1:0] l_port_q;
  logic [NP-1:0] dst_ports_q, key_ports_q, ingress;
  logic age_off_q, age_due_q, age_tick, cmd_busy_q, err_q;
  logic [2:0] cmd_op_q;
  logic [23:0] age_q;
  logic [2*NP-1:0] mode_q;
  logic [6:0] scnt_q;
  logic r_vld, r_sta, r_dyn, src_hit, m_hit, learn_new, refresh, drop;
  logic sw_last, sw_proc, sw_better;
  logic [1:0] pmode;
  logic [31:0] rmux;
  logic rerr, wr_acc;
  logic [2*NP-1:0] own2;

  function automatic logic [AW-1:0] hash_f(input logic [11:0] v, input logic [47:0] a);
    logic [59:0] k;
    logic [AW-1:0] h;
    k = {v, a};
    h = '0;
    for (int i = 0; i < 60; i++) begin
      h[i % AW] = h[i % AW] ^ k[i];
    end
    return h;
  endfunction

  function automatic logic [59:0] key_f(input logic [EW-1:0] e);
    return {e[E_VID +: 12], e[E_ADR +: 48]};
  endfunction

  function automatic logic [EW-1:0] mk_f(input logic sta, input logic [11:0] v,
                                         input logic [47:0] a, input logic [NP-1:0] p);
    return {p, a, v, ~sta, sta, 1'b1};
  endfunction

  function automatic logic [1:0] mode_f(input logic [PW-1:0] p, input logic [NP-1:0] own,
                                        input logic [2*NP-1:0] ext, input logic [2*NP-1:0] sw);
    return own[p] ? ext[2*p +: 2] : sw[2*p +: 2];
  endfunction

  mlt_ram #(.W(EW), .DEPTH(DEPTH), .AW(AW)) u_ram (
    .pclk(pclk),
    .rd_addr(rd_addr),
    .rd_data_q(rd_ent),
    .wr_en(we),
    .wr_addr(wa),
    .wr_data(wd)
  );

  mlt_age_timer #(.CPS(CYC_PER_SEC)) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .age_secs(age_q),
    .off(age_off_q),
    .tick_q(age_tick)
  );

  // Decisions on the entry just read
  always_comb begin
    r_vld = rd_ent[E_VLD];
    r_sta = r_vld && rd_ent[E_STA];
    r_dyn = r_vld && !rd_ent[E_STA];
    src_hit = r_vld && key_f(rd_ent) == {l_vid_q, l_src_q};
    m_hit = r_sta && key_f(rd_ent) == {key_vid_q, key_addr_q};
    pmode = mode_f(l_port_q, ext_own, ext_mode, mode_q);
    learn_new = pmode == MODE_AUTO && !src_hit && !r_sta;
    refresh = pmode == MODE_AUTO && src_hit && !r_sta;
    drop = pmode == MODE_SECURE && !(src_hit && r_sta);
    ingress = NP'(1) << l_port_q;
    sw_last = sw_cnt_q == CNT_END;
    sw_proc = sw_cnt_q != '0;
    sw_better = r_vld && key_f(rd_ent) >= {key_vid_q, key_addr_q}
      && (!best_vld_q || key_f(rd_ent) < key_f(best_q));
    go_lk = lk_valid && lk_ready;
    // Owned ports widened to two mode bits each
    for (int p = 0; p < NP; p++) begin
      own2[2*p +: 2] = {2{ext_own[p]}};
    end
  end

  // Next state and kind of sweep to start
  always_comb begin
    state_d = state_q;
    go_kind = SW_AGE;
    case (state_q)
      ST_IDLE: begin
        if (go_lk) begin
          state_d = ST_DST;
        end else if (cmd_busy_q) begin
          state_d = (cmd_op_q == CMD_ADD || cmd_op_q == CMD_DEL) ? ST_MGMT : ST_SWEEP;
          go_kind = cmd_op_q == CMD_FLUSH ? SW_FLUSH : SW_NEXT;
        end else if (age_due_q && !age_off_q) begin
          state_d = ST_SWEEP;
        end
      end
      ST_DST: state_d = ST_SRC;
      ST_SRC: state_d = ST_IDLE;
      ST_MGMT: state_d = ST_IDLE;
      ST_SWEEP: begin
        if (sw_last) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Table read and write requests
  always_comb begin
    rd_addr = hash_f(key_vid_q, key_addr_q);
    we = 1'b0;
    wa = hash_f(key_vid_q, key_addr_q);
    wd = '0;
    case (state_q)
      ST_IDLE: begin
        if (go_lk) begin
          rd_addr = hash_f(lk_vid, lk_destination_station_address);
        end
      end
      ST_DST: rd_addr = hash_f(l_vid_q, l_src_q);
      ST_SRC: begin
        we = learn_new || refresh;
        wa = hash_f(l_vid_q, l_src_q);
        wd = mk_f(1'b0, l_vid_q, l_src_q, ingress);
      end
      ST_MGMT: begin
        if (cmd_op_q == CMD_DEL) begin
          we = m_hit;
        end else begin
          we = m_hit || (!r_sta && scnt_q < STATIC_MAX);
          wd = mk_f(1'b1, key_vid_q, key_addr_q, key_ports_q);
        end
      end
      ST_SWEEP: begin
        rd_addr = sw_cnt_q[AW-1:0];
        if (sw_kind_q == SW_INIT) begin
          we = !sw_last;
          wa = sw_cnt_q[AW-1:0];
        end else begin
          wa = sw_cnt_q[AW-1:0] - 1'b1;
          if (sw_proc && r_dyn && sw_kind_q == SW_FLUSH) begin
            we = 1'b1;
          end
          if (sw_proc && r_dyn && sw_kind_q == SW_AGE && !age_off_q) begin
            we = 1'b1;
            wd = rd_ent[E_HIT] ? rd_ent & ~(EW'(1) << E_HIT) : '0;
          end
        end
      end
      default: ;
    endcase
  end

  // Control state, starts with a clearing sweep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_SWEEP;
      sw_kind_q <= SW_INIT;
    end else begin
      state_q <= state_d;
      if (state_q == ST_IDLE && state_d == ST_SWEEP) begin
        sw_kind_q <= go_kind;
      end
    end
  end

  // Sweep index and best get-next candidate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_cnt_q <= '0;
      best_vld_q <= 1'b0;
      best_q <= '0;
    end else if (state_q != ST_SWEEP) begin
      sw_cnt_q <= '0;
      best_vld_q <= 1'b0;
    end else begin
      sw_cnt_q <= sw_cnt_q + 1'b1;
      if (sw_kind_q == SW_NEXT && sw_proc && sw_better) begin
        best_vld_q <= 1'b1;
        best_q <= rd_ent;
      end
    end
  end

  // Frame lookup pipeline
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lk_ready <= 1'b0;
      l_vid_q <= '0;
      l_dst_q <= '0;
      l_src_q <= '0;
      l_port_q <= '0;
      dst_ports_q <= '0;
      res_valid <= 1'b0;
      res_ports <= '0;
      res_drop <= 1'b0;
    end else begin
      lk_ready <= state_d == ST_IDLE && !cmd_busy_q && !age_due_q;
      if (go_lk) begin
        l_vid_q <= lk_vid;
        l_dst_q <= lk_destination_station_address;
        l_src_q <= lk_source_station_address;
        l_port_q <= lk_port;
      end
      if (state_q == ST_DST) begin
        // Unknown destination floods; never back out the ingress
        if (r_vld && key_f(rd_ent) == {l_vid_q, l_dst_q}) begin
          dst_ports_q <= rd_ent[E_PRT +: NP] & ~ingress;
        end else begin
          dst_ports_q <= ~ingress;
        end
      end
      res_valid <= state_q == ST_SRC;
      if (state_q == ST_SRC) begin
        res_ports <= drop ? '0 : dst_ports_q;
        res_drop <= drop;
      end
    end
  end

  // Aging request, a new tick wins over the start clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_due_q <= 1'b0;
    end else if (age_off_q) begin
      age_due_q <= 1'b0;
    end else if (age_tick) begin
      age_due_q <= 1'b1;
    end else if (state_q == ST_IDLE && state_d == ST_SWEEP && !cmd_busy_q) begin
      age_due_q <= 1'b0;
    end
  end

  // APB: no wait states, read data latched in setup
  always_comb begin
    rmux = '0;
    rerr = 1'b0;
    if (paddr == OFS_CTRL) begin
      rmux[CTRL_AGE_OFF] = age_off_q;
    end else if (paddr == OFS_AGE) begin
      rmux[23:0] = age_q;
    end else if (paddr == OFS_MODE) begin
      rmux[2*NP-1:0] = mode_q;
    end else if (paddr == OFS_KVID) begin
      rmux[11:0] = key_vid_q;
    end else if (paddr == OFS_KLO) begin
      rmux = key_addr_q[31:0];
    end else if (paddr == OFS_KHI) begin
      rmux[15:0] = key_addr_q[47:32];
    end else if (paddr == OFS_KPRT) begin
      rmux[NP-1:0] = key_ports_q;
    end else if (paddr == OFS_CMD) begin
      rmux[STS_BUSY] = cmd_busy_q;
      rmux[STS_ERR] = err_q;
      rmux[STS_END] = res_end_q;
    end else if (paddr == OFS_RINFO) begin
      rmux[11:0] = res_ent_q[E_VID +: 12];
      rmux[INFO_STA] = res_ent_q[E_STA];
      rmux[INFO_END] = res_end_q;
    end else if (paddr == OFS_RLO) begin
      rmux = res_ent_q[E_ADR +: 32];
    end else if (paddr == OFS_RHI) begin
      rmux[15:0] = res_ent_q[E_ADR+32 +: 16];
    end else if (paddr == OFS_RPRT) begin
      rmux[NP-1:0] = res_ent_q[E_PRT +: NP];
    end else if (paddr == OFS_SCNT) begin
      rmux[6:0] = scnt_q;
    end else begin
      rerr = 1'b1;
    end
  end

  assign wr_acc = psel && penable && pready && pwrite;

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        prdata <= pwrite ? '0 : rmux;
        pslverr <= rerr;
      end
    end
  end

  // Configuration and key registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_off_q <= 1'b0;
      age_q <= AGE_RST;
      mode_q <= '0;
      key_vid_q <= '0;
      key_addr_q <= '0;
      key_ports_q <= '0;
    end else if (wr_acc) begin
      if (paddr == OFS_CTRL) begin
        age_off_q <= pwdata[CTRL_AGE_OFF];
      end else if (paddr == OFS_AGE) begin
        if (pwdata >= 32'(AGE_MIN) && pwdata <= 32'(AGE_MAX)) begin
          age_q <= pwdata[23:0];
        end
      end else if (paddr == OFS_MODE) begin
        for (int p = 0; p < NP; p++) begin
          if (!ext_own[p]) begin
            mode_q[2*p +: 2] <= pwdata[2*p +: 2];
          end
        end
      end else if (paddr == OFS_KVID) begin
        key_vid_q <= pwdata[11:0];
      end else if (paddr == OFS_KLO) begin
        key_addr_q[31:0] <= pwdata;
      end else if (paddr == OFS_KHI) begin
        key_addr_q[47:32] <= pwdata[15:0];
      end else if (paddr == OFS_KPRT) begin
        key_ports_q <= pwdata[NP-1:0];
      end
    end
  end

  // Commands, static count and search result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_busy_q <= 1'b0;
      cmd_op_q <= '0;
      err_q <= 1'b0;
      scnt_q <= '0;
      res_ent_q <= '0;
      res_end_q <= 1'b0;
    end else begin
      if (wr_acc && paddr == OFS_CMD) begin
        if (!cmd_busy_q && pwdata[2:0] >= CMD_ADD && pwdata[2:0] <= CMD_NEXT) begin
          cmd_busy_q <= 1'b1;
          cmd_op_q <= pwdata[2:0];
          err_q <= 1'b0;
        end else begin
          err_q <= 1'b1;
        end
      end
      if (state_q == ST_MGMT) begin
        cmd_busy_q <= 1'b0;
        err_q <= !we || (wr_acc && paddr == OFS_CMD); // Refused write in this cycle still sets it
        if (we && cmd_op_q == CMD_ADD && !m_hit) begin
          scnt_q <= scnt_q + 7'h01;
        end
        if (we && cmd_op_q == CMD_DEL) begin
          scnt_q <= scnt_q - 7'h01;
        end
      end
      if (state_q == ST_SWEEP && sw_last && sw_kind_q != SW_INIT && sw_kind_q != SW_AGE) begin
        cmd_busy_q <= 1'b0;
        if (sw_kind_q == SW_NEXT) begin
          // Last slot is still on the read port at the final count
          res_ent_q <= sw_better ? rd_ent : best_q;
          res_end_q <= !(best_vld_q || sw_better);
        end
      end
    end
  end

  a_lookup_answer: assert property (@(posedge pclk) disable iff (!presetn)
    go_lk |-> ##3 res_valid)
    else $error("lookup gave no answer");
  a_secure_drop: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_SRC && pmode == MODE_SECURE && !(src_hit && r_sta) |=> res_drop && res_ports == '0)
    else $error("secure port forwarded unknown source");
  a_static_kept: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_SRC || (state_q == ST_SWEEP && sw_kind_q != SW_INIT && sw_proc)) && r_sta |-> !we)
    else $error("static entry overwritten");
  a_age_off_hold: assert property (@(posedge pclk) disable iff (!presetn)
    age_off_q && state_q == ST_SWEEP && sw_kind_q == SW_AGE |-> !we)
    else $error("aging while disabled");
  a_off_no_learn: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_SRC && pmode != MODE_AUTO |-> !we)
    else $error("learning in non-auto mode");
  a_learn_empty: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_SRC && pmode == MODE_AUTO && !r_vld |-> we && wd[E_HIT] && !wd[E_STA])
    else $error("unknown source not learned");
  a_static_cap: assert property (@(posedge pclk) disable iff (!presetn)
    scnt_q <= STATIC_MAX)
    else $error("static count over limit");
  a_mode_owned: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == OFS_MODE |=> ((mode_q ^ $past(mode_q)) & $past(own2)) == '0)
    else $error("owned mode was written");
  a_age_reset: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> age_q == AGE_RST)
    else $error("aging time reset wrong");
  a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
endmodule

// ---- verification/mlt_fwd_model.sv ----
`timescale 1ns/100ps
// Forwarding pipeline side: offers one lookup, fast or slow
module mlt_fwd_model (
  input wire logic pclk,
  input wire logic req,
  input wire logic [1:0] dly,
  input wire logic [1:0] port,
  input wire logic [11:0] vid,
  input wire logic [47:0] da,
  input wire logic [47:0] sa,
  input wire logic lk_ready,
  output logic lk_valid,
  output logic [1:0] lk_port,
  output logic [11:0] lk_vid,
  output logic [47:0] lk_da,
  output logic [47:0] lk_sa,
  output logic busy
);
  logic [1:0] wait_q;
  // Idle values at time zero
  initial begin
    lk_valid = 1'b0;
    busy = 1'b0;
    wait_q = 2'h0;
    lk_port = 2'h0;
    lk_vid = 12'h000;
    lk_da = 48'h0;
    lk_sa = 48'h0;
  end
  // Hold until taken, then scramble the released fields
  always @(posedge pclk) begin
    if (lk_valid && lk_ready) begin
      lk_valid <= 1'b0;
      busy <= 1'b0;
      lk_port <= ~lk_port;
      lk_vid <= ~lk_vid;
      lk_da <= ~lk_da;
      lk_sa <= ~lk_sa;
    end else if (req && !busy) begin
      busy <= 1'b1;
      wait_q <= dly;
      lk_port <= port;
      lk_vid <= vid;
      lk_da <= da;
      lk_sa <= sa;
    end else if (busy && !lk_valid) begin
      if (wait_q == 2'h0) lk_valid <= 1'b1;
      else wait_q <= wait_q - 2'h1;
    end
  end
endmodule

// ---- verification/mac_address_learning_table_test.sv ----
`timescale 1ns/100ps
module mac_address_learning_table_test;
  import mlt_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdv, e_v, m_v;
  logic pready, pslverr, lk_valid, lk_ready, res_valid, res_drop, busy;
  logic [1:0] lk_port;
  logic [11:0] lk_vid;
  logic [47:0] lk_da, lk_sa;
  logic [3:0] res_ports;
  logic [3:0] ext_own = 4'h0;
  logic [7:0] ext_mode = 8'h00;
  logic m_req = 1'b0;
  logic [1:0] m_dly = 2'h0;
  logic [1:0] m_port = 2'h0;
  logic [47:0] m_da = 48'h0;
  logic [47:0] m_sa = 48'h0;
  logic [15:0] lf = 16'h0016;
  logic [31:0] rd_q[$], mk_q[$];
  logic [4:0] res_q[$];
  int fail_count = 0;
  int total_checks = 0;

  mlt_table #(.NP(4), .DEPTH(64), .CYC_PER_SEC(10)) u_mlt_table (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lk_valid(lk_valid), .lk_ready(lk_ready), .lk_port(lk_port), .lk_vid(lk_vid),
    .lk_destination_station_address(lk_da), .lk_source_station_address(lk_sa),
    .ext_own(ext_own), .ext_mode(ext_mode), .res_valid(res_valid), .res_ports(res_ports),
    .res_drop(res_drop));

  mlt_fwd_model u_mlt_fwd_model (
    .pclk(pclk), .req(m_req), .dly(m_dly), .port(m_port), .vid(12'h001), .da(m_da),
    .sa(m_sa), .lk_ready(lk_ready), .lk_valid(lk_valid), .lk_port(lk_port),
    .lk_vid(lk_vid), .lk_da(lk_da), .lk_sa(lk_sa), .busy(busy));

  // Clock generator
  initial begin
    forever #5 pclk = ~pclk;
  end

  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic end_sim();
    if (fail_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic tmo();
    fail_count++;
    end_sim();
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; a read notes its expected word and mask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    int n;
    n = 0;
    if (!w) begin
      rd_q.push_back(d);
      mk_q.push_back(m);
    end
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n == 50) tmo();
    rdv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Command issue, then poll busy
  task automatic cmd(input logic [2:0] c);
    int n;
    n = 0;
    apb(1'b1, OFS_CMD, {29'h0, c}, 32'h0);
    rdv = 32'h1;
    while (rdv[STS_BUSY] && n < 500) begin
      n++;
      apb(1'b0, OFS_CMD, 32'h0, 32'h0);
    end
    if (n == 500) tmo();
  endtask

  task automatic key(input logic [11:0] v, input logic [31:0] lo, input logic [31:0] p);
    apb(1'b1, OFS_KVID, {20'h0, v}, 32'h0);
    apb(1'b1, OFS_KLO, lo, 32'h0);
    apb(1'b1, OFS_KHI, 32'h0, 32'h0);
    apb(1'b1, OFS_KPRT, p, 32'h0);
  endtask

  // Lookup through the model; waits for its result
  task automatic look(input logic [1:0] p, input logic [47:0] da, input logic [47:0] sa, input logic [4:0] e);
    int n;
    n = 0;
    res_q.push_back(e);
    m_port <= p;
    m_da <= da;
    m_sa <= sa;
    m_dly <= lf[1:0];
    m_req <= 1'b1;
    lf = nx(lf);
    @(posedge pclk);
    m_req <= 1'b0;
    while (res_q.size() != 0 && n < 5000) begin
      n++;
      @(posedge pclk);
    end
    if (n == 5000) tmo();
  endtask

  // Read watcher
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      e_v = rd_q.pop_front();
      m_v = mk_q.pop_front();
      if (m_v != 32'h0) check("prdata", prdata & m_v, e_v & m_v);
    end
  end

  // Result watcher
  always @(posedge pclk) begin
    if (res_valid) check("result", {27'h0, res_drop, res_ports}, {27'h0, res_q.pop_front()});
  end

  // Main sequence
  initial begin
    int n;
    n = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    while (!lk_ready && n < 500) begin
      n++;
      @(posedge pclk);
    end
    if (n == 500) tmo();
    apb(1'b0, OFS_AGE, 32'd300, 32'hFFFFFF);
    check("pslverr", {31'h0, pslverr}, 32'h0);
    apb(1'b0, 8'h40, 32'h0, 32'hFFFFFFFF);
    check("pslverr", {31'h0, pslverr}, 32'h1);
    apb(1'b1, OFS_AGE, 32'd10000000, 32'h0);
    apb(1'b0, OFS_AGE, 32'd10000000, 32'hFFFFFF);
    apb(1'b1, OFS_AGE, 32'd9, 32'h0);
    apb(1'b0, OFS_AGE, 32'd10000000, 32'hFFFFFF);
    key(12'h001, 32'h1, 32'h4);
    cmd(CMD_ADD);
    apb(1'b0, OFS_CMD, 32'h0, 32'h3);
    apb(1'b0, OFS_SCNT, 32'h1, 32'h7F);
    look(2'd0, 48'h1, 48'h2, 5'h04);
    look(2'd1, 48'h2, 48'h1, 5'h01);
    key(12'h000, 32'h0, 32'h0);
    cmd(CMD_NEXT);
    apb(1'b0, OFS_RINFO, 32'h00010001, 32'h00030FFF);
    apb(1'b0, OFS_RLO, 32'h1, 32'hFFFFFFFF);
    apb(1'b0, OFS_RPRT, 32'h4, 32'hF);
    key(12'h001, 32'h2, 32'h0);
    cmd(CMD_NEXT);
    apb(1'b0, OFS_RINFO, 32'h00000001, 32'h00030FFF);
    apb(1'b0, OFS_RPRT, 32'h1, 32'hF);
    key(12'h001, 32'h3, 32'h0);
    cmd(CMD_NEXT);
    apb(1'b0, OFS_RINFO, 32'h00020000, 32'h00020000);
    key(12'h001, 32'h1, 32'h6);
    cmd(CMD_ADD);
    look(2'd0, 48'h1, 48'h1, 5'h06);
    cmd(CMD_FLUSH);
    look(2'd1, 48'h2, 48'h1, 5'h0D);
    look(2'd3, 48'h1, 48'h1, 5'h06);
    ext_own <= 4'h1;
    apb(1'b1, OFS_MODE, 32'h61, 32'h0);
    apb(1'b0, OFS_MODE, 32'h60, 32'hFF);
    look(2'd2, 48'h1, {32'hC0000000, lf}, 5'h10);
    look(2'd2, 48'h2, 48'h1, 5'h0B);
    look(2'd3, 48'h1, 48'h4, 5'h06);
    look(2'd1, 48'h4, 48'h1, 5'h0D);
    look(2'd0, 48'h1, 48'h5, 5'h06);
    look(2'd1, 48'h5, 48'h1, 5'h01);
    // Owner switches port 0 to disabled: no learning there
    ext_mode <= 8'h01;
    look(2'd0, 48'h1, 48'h7, 5'h06);
    look(2'd1, 48'h7, 48'h1, 5'h0D);
    ext_mode <= 8'h00;
    ext_own <= 4'h0;
    apb(1'b1, OFS_CTRL, 32'h1, 32'h0);
    apb(1'b1, OFS_AGE, 32'd10, 32'h0);
    look(2'd0, 48'h1, 48'h6, 5'h06);
    repeat (400) @(posedge pclk);
    look(2'd1, 48'h6, 48'h1, 5'h01);
    apb(1'b1, OFS_CTRL, 32'h0, 32'h0);
    repeat (400) @(posedge pclk);
    look(2'd1, 48'h6, 48'h1, 5'h0D);
    // Key that lands in the last table slot
    look(2'd0, 48'h1, 48'h3E, 5'h06);
    key(12'h001, 32'h2, 32'h0);
    cmd(CMD_NEXT);
    apb(1'b0, OFS_RINFO, 32'h00000001, 32'h00030FFF);
    apb(1'b0, OFS_RLO, 32'h3E, 32'hFFFFFFFF);
    key(12'h001, 32'h1, 32'h0);
    cmd(CMD_DEL);
    apb(1'b0, OFS_CMD, 32'h0, 32'h2);
    apb(1'b0, OFS_SCNT, 32'h0, 32'h7F);
    cmd(CMD_DEL);
    apb(1'b0, OFS_CMD, 32'h2, 32'h2);
    end_sim();
  end
endmodule
